// ==== far_side_model.sv ====
/*
  Far side of the phase management block: a master controller on the
  phase-drop lines and the strap resistors on phase three and four.
  Assumes the block's line enables are high only while it drives.
*/
`timescale 1ns/1ps

module far_side_model #(
  parameter int LOW_CYC = 2
) (
  input wire logic ref_clk_i,
  input wire logic drive_i,
  input wire logic [1:0] code_i,
  input wire logic boot_i,
  input wire logic [1:0] dut_out_i,
  input wire logic [1:0] dut_oe_i,
  input wire logic [1:0] strap_i,
  input wire logic [1:0] mod_i,
  input wire logic [1:0] mod_oe_i,
  output logic [1:0] line_o,
  output logic [1:0] sense_o
);
  int low_cnt = 0;
  logic flip = 1'b0;
  logic [1:0] far;

  // Refresh low count; an undriven wire wanders so no stale level reads
  always_ff @(posedge ref_clk_i) begin
    flip <= ~flip;
    if (boot_i) begin
      low_cnt <= LOW_CYC;
    end else if (low_cnt != 0) begin
      low_cnt <= low_cnt - 1;
    end
  end

  assign far = (low_cnt != 0) ? 2'h0 : code_i;
  // lines left open wander when nobody drives them
  assign line_o[0] = dut_oe_i[0] ? dut_out_i[0] : (drive_i ? far[0] : flip);
  assign line_o[1] = dut_oe_i[1] ? dut_out_i[1] : (drive_i ? far[1] : ~flip);
  assign sense_o = (mod_oe_i & mod_i) | (~mod_oe_i & strap_i);
endmodule

// ==== phase_mgmt.sv ====
/*
  Phase management of a four-phase PWM controller: interleaved modulation
  outputs, phase-count straps, phase-drop line signalling with boot-refresh
  pulse, and gate driver enable.
  Assumes pins arrive asynchronously and fault and boot-refresh requests
  come from logic on ref_clk_i.
*/
// Operation
// - Master drives both lines with phase count
// - Slave reads both lines as inputs
// - Apply phase change three switching cycles later
// - Buck boot refresh: one PLL tick low
// - One modulation output per phase
// - Phase three strapped high: two phases
// - Phase four strapped high: three phases
// - Driver enable high when ready
// - Driver enable low when disabled or faulted
// - Software override forces driver enable low
// - Tri-level select allows mid-level idle state
`timescale 1ns/1ps
`include "phase_mgmt_defines.svh"

module phase_mgmt import phase_mgmt_pkg::*; #(
  parameter int PLL_DIV = 10,
  parameter logic [11:0] PD_COUNT_MAP = 12'h8D1
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic hiccup_fault_i,
  input wire logic latch_fault_i,
  input wire logic boot_refresh_req_i,
  input wire logic tri_level_sel_i,
  input wire logic phase_three_sense_i,
  input wire logic phase_four_sense_i,
  input wire logic phase_drop_line_zero_i,
  output logic phase_drop_line_zero_o,
  output logic phase_drop_line_zero_oe_o,
  input wire logic phase_drop_line_one_i,
  output logic phase_drop_line_one_o,
  output logic phase_drop_line_one_oe_o,
  output logic phase_one_modulation_out_o,
  output logic phase_one_modulation_oe_o,
  output logic phase_two_modulation_out_o,
  output logic phase_two_modulation_oe_o,
  output logic phase_three_modulation_out_o,
  output logic phase_three_modulation_oe_o,
  output logic phase_four_modulation_out_o,
  output logic phase_four_modulation_oe_o,
  output logic gate_driver_enable_out_o,
  output logic boot_refresh_start_o
);

  localparam int TICK_W = $clog2(PLL_DIV + 1);
  localparam int QUAL_W = TICK_W + 1;

  ctrl_t ctrl_reg;
  logic [2:0] phase_req_reg;
  logic [3:0] duty_reg;
  strap_state_t strap_state_reg;
  logic [3:0] settle_cnt_reg;
  logic [2:0] strap_max_reg;
  logic [1:0] strap_mode_reg;
  logic [TICK_W-1:0] tick_cnt_reg;
  logic [3:0] slot_reg;
  logic pll_tick;
  logic cycle_end;
  logic [4:0] sense_level;
  logic tri_level;
  logic [1:0] line_seen;
  logic [1:0] line_prev_reg;
  logic [1:0] line_qual_reg;
  logic [QUAL_W-1:0] stable_cnt_reg;
  logic [1:0] master_code;
  logic [1:0] line_level;
  logic [1:0] pend_code_reg;
  logic [1:0] pend_cnt_reg;
  logic [2:0] active_count_reg;
  logic boot_active_reg;
  logic [TICK_W-1:0] boot_cnt_reg;
  logic ready;
  logic [3:0] mod_reg;
  logic [3:0] oe_reg;
  logic [3:0] strap_off;

  // Line code to phase count, shared by master and slave
  function automatic logic [2:0] code_to_count(input logic [1:0] code);
    return PD_COUNT_MAP[4'(code) * 4'h3 +: 3];
  endfunction

  function automatic logic [1:0] count_to_code(input logic [2:0] cnt);
    logic [1:0] code;
    code = 2'h3;
    for (int i = 0; i < 4; i++) begin
      if (PD_COUNT_MAP[i*3 +: 3] == cnt) begin
        code = 2'(i);
      end
    end
    return code;
  endfunction

  // Evenly spaced start slot of phase k among n active phases
  function automatic logic [3:0] phase_start(input logic [1:0] k, input logic [2:0] n);
    logic [3:0] s;
    unique case (n)
      3'h4: s = 4'(k) * 4'h3;
      3'h3: s = 4'(k) * 4'h4;
      3'h2: s = 4'(k) * 4'h6;
      default: s = 4'h0;
    endcase
    return s;
  endfunction

  // Pins through the three-stage synchroniser
  pin_sync #(
    .WIDTH(5)
  ) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i({tri_level_sel_i, phase_drop_line_one_i, phase_drop_line_zero_i,
            phase_four_sense_i, phase_three_sense_i}),
    .level_o(sense_level)
  );
  assign line_seen = sense_level[3:2];
  assign tri_level = sense_level[4];

  // Register writes; unmapped writes are dropped
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= ctrl_t'(`CTRL_RESET);
      phase_req_reg <= `PHASE_RESET;
      duty_reg <= `DUTY_RESET;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `REG_CTRL_OFS) begin
        ctrl_reg <= ctrl_t'(reg_wdata_i[3:0]);
      end
      if (reg_addr_i == `REG_PHASE_OFS) begin
        phase_req_reg <= reg_wdata_i[2:0];
      end
      if (reg_addr_i == `REG_DUTY_OFS) begin
        duty_reg <= reg_wdata_i[3:0];
      end
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `REG_CTRL_OFS: reg_rdata_o <= {28'h000_0000, ctrl_reg};
        `REG_PHASE_OFS: reg_rdata_o <= {29'h0000_0000, phase_req_reg};
        `REG_DUTY_OFS: reg_rdata_o <= {28'h000_0000, duty_reg};
        `REG_STATUS_OFS: reg_rdata_o <= {20'h0_0000, ready, strap_mode_reg,
          gate_driver_enable_out_o, line_level, line_seen, 1'b0, active_count_reg};
        default: reg_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  // phase four tied high
  // Straps are taken after settling, while outputs three and four float
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      strap_state_reg <= ST_SETTLE;
      settle_cnt_reg <= 4'h0;
      strap_max_reg <= 3'h4;
      strap_mode_reg <= 2'h0;
    end else begin
      unique case (strap_state_reg)
        ST_SETTLE: begin
          settle_cnt_reg <= settle_cnt_reg + 4'h1;
          if (settle_cnt_reg == `STRAP_SETTLE) begin
            strap_state_reg <= ST_RUN;
            if (sense_level[0]) begin
              strap_max_reg <= 3'h2;
              strap_mode_reg <= 2'h1;
            end else if (sense_level[1]) begin
              strap_max_reg <= 3'h3;
              strap_mode_reg <= 2'h2;
            end
          end
        end
        ST_RUN: begin
          settle_cnt_reg <= settle_cnt_reg;
        end
      endcase
    end
  end
  assign strap_off = {strap_state_reg == ST_SETTLE || strap_mode_reg != 2'h0,
                      strap_state_reg == ST_SETTLE || strap_mode_reg == 2'h1, 2'b00};

  // PLL tick divider and twelve-slot switching cycle
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      tick_cnt_reg <= '0;
      slot_reg <= 4'h0;
    end else if (pll_tick) begin
      tick_cnt_reg <= '0;
      slot_reg <= (slot_reg == `LAST_SLOT) ? 4'h0 : slot_reg + 4'h1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
    end
  end
  assign pll_tick = (tick_cnt_reg == TICK_W'(PLL_DIV - 1));
  assign cycle_end = pll_tick && (slot_reg == `LAST_SLOT);

  // master boot-refresh pulse, one PLL tick long, buck only
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      boot_active_reg <= 1'b0;
      boot_cnt_reg <= '0;
    end else if (boot_active_reg) begin
      boot_cnt_reg <= boot_cnt_reg + TICK_W'(1);
      if (boot_cnt_reg == TICK_W'(PLL_DIV - 1)) begin
        boot_active_reg <= 1'b0;
      end
    end else if (boot_refresh_req_i && ctrl_reg.master && ctrl_reg.buck && ctrl_reg.enable) begin
      boot_active_reg <= 1'b1;
      boot_cnt_reg <= '0;
    end
  end

  assign master_code = count_to_code(phase_req_reg);
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      phase_drop_line_zero_o <= 1'b0;
      phase_drop_line_one_o <= 1'b0;
      phase_drop_line_zero_oe_o <= 1'b0;
      phase_drop_line_one_oe_o <= 1'b0;
    end else begin
      phase_drop_line_zero_o <= master_code[0] && !boot_active_reg;
      phase_drop_line_one_o <= master_code[1] && !boot_active_reg;
      phase_drop_line_zero_oe_o <= ctrl_reg.master;
      phase_drop_line_one_oe_o <= ctrl_reg.master;
    end
  end

  // slave qualifies levels stable for two PLL ticks
  // a short low-going excursion starts boot refresh
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      line_prev_reg <= 2'h0;
      line_qual_reg <= 2'h0;
      stable_cnt_reg <= '0;
      boot_refresh_start_o <= 1'b0;
    end else begin
      line_prev_reg <= line_seen;
      boot_refresh_start_o <= 1'b0;
      if (line_seen != line_prev_reg) begin
        stable_cnt_reg <= '0;
        if (line_seen == line_qual_reg && (line_prev_reg & ~line_qual_reg) == 2'h0 &&
            !ctrl_reg.master && ctrl_reg.buck && ctrl_reg.enable) begin
          boot_refresh_start_o <= 1'b1;
        end
      end else if (stable_cnt_reg != QUAL_W'(2 * PLL_DIV)) begin
        stable_cnt_reg <= stable_cnt_reg + QUAL_W'(1);
      end else begin
        line_qual_reg <= line_seen;
      end
    end
  end
  assign line_level = ctrl_reg.master ? master_code : line_qual_reg;

  // apply new count on the third cycle end after a change
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pend_code_reg <= 2'h3;
      pend_cnt_reg <= `CYCLES_TO_APPLY;
      active_count_reg <= 3'h4;
    end else if (line_level != pend_code_reg) begin
      pend_code_reg <= line_level;
      pend_cnt_reg <= 2'h0;
    end else if (cycle_end) begin
      if (pend_cnt_reg != `CYCLES_TO_APPLY) begin
        pend_cnt_reg <= pend_cnt_reg + 2'h1;
      end
      if (pend_cnt_reg >= 2'h2) begin
        // Own strap limit caps whatever the system asks for
        active_count_reg <= (code_to_count(pend_code_reg) > strap_max_reg) ?
          strap_max_reg : code_to_count(pend_code_reg);
      end
    end
  end

  // ready once straps taken and enabled
  // disable and faults pull enable low
  // override bit low forces enable low
  assign ready = (strap_state_reg == ST_RUN) && ctrl_reg.enable &&
                 !hiccup_fault_i && !latch_fault_i;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      gate_driver_enable_out_o <= 1'b0;
    end else begin
      gate_driver_enable_out_o <= ready && ctrl_reg.override_n_low;
    end
  end

  // idle when dropped, start slots interleaved
  // tri-level idles by releasing the pin to mid-level
  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_phase
      logic on;
      logic [3:0] rel;
      assign on = (3'(k) < active_count_reg) && gate_driver_enable_out_o;
      assign rel = (slot_reg >= phase_start(2'(k), active_count_reg)) ?
        slot_reg - phase_start(2'(k), active_count_reg) :
        slot_reg + `TICKS_PER_CYCLE - phase_start(2'(k), active_count_reg);
      always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
          mod_reg[k] <= 1'b0;
          oe_reg[k] <= 1'b0;
        end else begin
          mod_reg[k] <= on && !strap_off[k] && (rel < duty_reg);
          oe_reg[k] <= !strap_off[k] && (!tri_level || on);
        end
      end
    end
  endgenerate
  // Output pins straight from flops
  assign phase_one_modulation_out_o = mod_reg[0];
  assign phase_two_modulation_out_o = mod_reg[1];
  assign phase_three_modulation_out_o = mod_reg[2];
  assign phase_four_modulation_out_o = mod_reg[3];
  assign phase_one_modulation_oe_o = oe_reg[0];
  assign phase_two_modulation_oe_o = oe_reg[1];
  assign phase_three_modulation_oe_o = oe_reg[2];
  assign phase_four_modulation_oe_o = oe_reg[3];

  // Assertions
  master_line_drive_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    ctrl_reg.master && !boot_active_reg |=> phase_drop_line_zero_oe_o &&
      phase_drop_line_zero_o == $past(master_code[0]) && phase_drop_line_one_oe_o)
    else $error("master not driving line code");

  slave_release_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !ctrl_reg.master |=> !phase_drop_line_zero_oe_o && !phase_drop_line_one_oe_o)
    else $error("slave drives phase-drop lines");

  count_change_time_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    $changed(active_count_reg) |-> $past(cycle_end) && $past(pend_cnt_reg) >= 2'h2)
    else $error("phase count changed off schedule");

  boot_pulse_len_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    $fell(boot_active_reg) |-> $past(boot_cnt_reg) == TICK_W'(PLL_DIV - 1))
    else $error("boot pulse not one tick long");

  two_phase_strap_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    strap_mode_reg == 2'h1 |=> !phase_three_modulation_oe_o && !phase_four_modulation_oe_o)
    else $error("strapped outputs driven in two-phase mode");

  three_phase_strap_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    strap_mode_reg == 2'h2 |=> !phase_four_modulation_oe_o && !phase_four_modulation_out_o)
    else $error("phase four driven in three-phase mode");

  drv_fault_low_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    hiccup_fault_i || latch_fault_i || !ctrl_reg.enable |=> !gate_driver_enable_out_o)
    else $error("driver enable high during fault or disable");

  drv_override_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !ctrl_reg.override_n_low [*2] |-> !gate_driver_enable_out_o)
    else $error("override did not hold driver enable low");

  drv_ready_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    gate_driver_enable_out_o |-> $past(ready))
    else $error("driver enable high without readiness");

  dropped_phase_idle_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    active_count_reg < 3'h4 && $stable(active_count_reg) |=> !phase_four_modulation_out_o)
    else $error("dropped phase toggled");

  two_level_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !tri_level && strap_state_reg == ST_RUN |=> phase_one_modulation_oe_o)
    else $error("two-level output released");

  boot_pulse_c: cover property (@(posedge ref_clk_i) $rose(boot_active_reg));
  slave_boot_c: cover property (@(posedge ref_clk_i) boot_refresh_start_o);
  count_drop_c: cover property (@(posedge ref_clk_i) $fell(active_count_reg[2]));
  strap_three_c: cover property (@(posedge ref_clk_i) strap_mode_reg == 2'h2);

endmodule

// ==== phase_mgmt_defines.svh ====
/*
  Offsets, field positions, reset values and timing counts of the
  phase management block. Assumes a 32-bit plain register port.
*/
`ifndef PHASE_MGMT_DEFINES_SVH
`define PHASE_MGMT_DEFINES_SVH

// Register offsets (byte addresses)
`define REG_CTRL_OFS 8'h00
`define REG_PHASE_OFS 8'h04
`define REG_DUTY_OFS 8'h08
`define REG_STATUS_OFS 8'h0C

// Control field positions
`define CTRL_ENABLE_BIT 0
`define CTRL_MASTER_BIT 1
`define CTRL_BUCK_BIT 2
`define CTRL_OVERRIDE_BIT 3

// Reset values
`define CTRL_RESET 4'h8
`define PHASE_RESET 3'h4
`define DUTY_RESET 4'h0

// Timing counts
`define TICKS_PER_CYCLE 4'hC
`define LAST_SLOT 4'hB
`define CYCLES_TO_APPLY 2'h3
`define STRAP_SETTLE 4'h8

`endif

// ==== phase_mgmt_pkg.sv ====
/*
  Types shared by the phase management block.
  Assumes the defines header supplies all numbers.
*/
package phase_mgmt_pkg;

  // Control register fields, msb first
  typedef struct packed {
    logic override_n_low;
    logic buck;
    logic master;
    logic enable;
  } ctrl_t;

  // Strap sensing sequence
  typedef enum logic {
    ST_SETTLE,
    ST_RUN
  } strap_state_t;

endpackage

// ==== pin_sync.sv ====
/*
  Three-stage synchroniser for pin inputs.
  Assumes inputs are asynchronous to ref_clk_i; a new level is taken
  once stages two and three agree.
*/
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  // Shift chain; stage one feeds only stage two
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end else begin
      stage1_reg <= pin_i;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // Per-bit agreement filter
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_agree
      always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
          level_o[b] <= 1'b0;
        end else if (stage2_reg[b] == stage3_reg[b]) begin
          level_o[b] <= stage3_reg[b];
        end
      end
    end
  endgenerate

endmodule

// ==== tb.sv ====
/*
  Self-checking bench of the phase management block.
  Assumes PLL_DIV of 2, so a switching cycle is 24 reference cycles.
*/
`timescale 1ns/1ps
`include "phase_mgmt_defines.svh"

module tb;
  import phase_mgmt_pkg::*;
  localparam int PD = 2;
  localparam int SW = 12 * PD;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic hic = 1'b0;
  logic lat = 1'b0;
  logic boot = 1'b0;
  logic [1:0] strap = 2'h0;
  logic tri_sel = 1'b0;
  logic fdrv = 1'b0;
  logic [1:0] fcode = 2'h0;
  logic fboot = 1'b0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [1:0] ln;
  logic [1:0] l_o;
  logic [1:0] l_oe;
  logic [1:0] sense;
  logic [3:0] m_o;
  logic [3:0] m_oe;
  logic bstart;
  logic drv;
  logic [3:0] smp [SW];
  int err_count = 0;
  int checks_done = 0;

  // Free-running reference clock
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  phase_mgmt #(.PLL_DIV(PD)) phase_mgmt_inst (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .hiccup_fault_i(hic), .latch_fault_i(lat),
    .boot_refresh_req_i(boot), .tri_level_sel_i(tri_sel),
    .phase_three_sense_i(sense[0]), .phase_four_sense_i(sense[1]),
    .phase_drop_line_zero_i(ln[0]), .phase_drop_line_zero_o(l_o[0]),
    .phase_drop_line_zero_oe_o(l_oe[0]), .phase_drop_line_one_i(ln[1]),
    .phase_drop_line_one_o(l_o[1]), .phase_drop_line_one_oe_o(l_oe[1]),
    .phase_one_modulation_out_o(m_o[0]), .phase_one_modulation_oe_o(m_oe[0]),
    .phase_two_modulation_out_o(m_o[1]), .phase_two_modulation_oe_o(m_oe[1]),
    .phase_three_modulation_out_o(m_o[2]), .phase_three_modulation_oe_o(m_oe[2]),
    .phase_four_modulation_out_o(m_o[3]), .phase_four_modulation_oe_o(m_oe[3]),
    .gate_driver_enable_out_o(drv), .boot_refresh_start_o(bstart));

  far_side_model #(.LOW_CYC(PD)) far_side_model_inst (
    .ref_clk_i(ref_clk_i), .drive_i(fdrv), .code_i(fcode), .boot_i(fboot),
    .dut_out_i(l_o), .dut_oe_i(l_oe), .strap_i(strap), .mod_i(m_o[3:2]),
    .mod_oe_i(m_oe[3:2]), .line_o(ln), .sense_o(sense));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    chk({31'h0000_0000, g}, {31'h0000_0000, e});
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  // One-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic do_reset(input logic [1:0] s);
    @(posedge ref_clk_i);
    strap <= s;
    sys_rst_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    cyc(20);
  endtask

  task automatic t_regs();
    rd_reg(`REG_CTRL_OFS, d);
    chk(d, 32'h0000_0008);
    rd_reg(`REG_PHASE_OFS, d);
    chk(d, 32'h0000_0004);
    wr_reg(8'h10, 32'h0000_000F);
    rd_reg(8'h10, d);
    chk(d, 32'h0000_0000);
    cyc(1);
    chk(rdata, 32'h0000_0000);
  endtask

  task automatic t_drv();
    wr_reg(`REG_CTRL_OFS, 32'h0000_0009);
    cyc(2);
    chk_bit(drv, 1'b1);
    for (int f = 0; f < 2; f++) begin
      @(posedge ref_clk_i);
      hic <= (f == 0);
      lat <= (f == 1);
      cyc(3);
      chk_bit(drv, 1'b0);
      @(posedge ref_clk_i);
      hic <= 1'b0;
      lat <= 1'b0;
      cyc(3);
      chk_bit(drv, 1'b1);
    end
    wr_reg(`REG_CTRL_OFS, 32'h0000_0001);
    cyc(2);
    chk_bit(drv, 1'b0);
    wr_reg(`REG_CTRL_OFS, 32'h0000_0008);
    cyc(2);
    chk_bit(drv, 1'b0);
    @(posedge ref_clk_i);
    tri_sel <= 1'b1;
    cyc(6);
    chk_bit(m_oe[0], 1'b0);
    @(posedge ref_clk_i);
    tri_sel <= 1'b0;
    cyc(6);
    chk_bit(m_oe[0], 1'b1);
  endtask

  // Each count goes out as its code; count lags by three cycles
  task automatic t_master();
    wr_reg(`REG_CTRL_OFS, 32'h0000_000B);
    wr_reg(`REG_PHASE_OFS, 32'h0000_0004);
    cyc(100);
    for (int n = 1; n < 5; n++) begin
      wr_reg(`REG_PHASE_OFS, 32'(n));
      cyc(2);
      chk({30'h0000_0000, l_oe}, 32'h0000_0003);
      chk({30'h0000_0000, l_o}, 32'(n - 1));
      cyc(40);
      rd_reg(`REG_STATUS_OFS, d);
      chk({29'h0000_0000, d[2:0]}, (n == 1) ? 32'h0000_0004 : 32'(n - 1));
      cyc(50);
      rd_reg(`REG_STATUS_OFS, d);
      chk({29'h0000_0000, d[2:0]}, 32'(n));
    end
  endtask

  // Refresh pulse in buck only, one tick long
  task automatic t_boot();
    int lows;
    for (int i = 0; i < 2; i++) begin
      wr_reg(`REG_CTRL_OFS, (i == 0) ? 32'h0000_000F : 32'h0000_000B);
      cyc(4);
      lows = 0;
      @(posedge ref_clk_i);
      boot <= 1'b1;
      @(posedge ref_clk_i);
      boot <= 1'b0;
      for (int t = 0; t < 6; t++) begin
        #1 lows += (l_o === 2'h0);
        @(posedge ref_clk_i);
      end
      chk(32'(lows), (i == 0) ? 32'(PD) : 32'h0000_0000);
      #1 chk({30'h0000_0000, l_o}, 32'h0000_0003);
    end
  endtask

  task automatic grab(output logic [3:0] oes);
    oes = 4'h0;
    for (int t = 0; t < SW; t++) begin
      @(posedge ref_clk_i);
      #1 smp[t] = m_o;
      oes = oes | m_oe;
    end
  endtask

  // Duty per phase, rotation by phase slot, idle dropped phases
  task automatic t_phases(input int n, input bit strapped);
    logic [3:0] oes;
    int hi;
    int bad;
    grab(oes);
    for (int k = 0; k < 4; k++) begin
      hi = 0;
      bad = 0;
      for (int t = 0; t < SW; t++) begin
        hi += (smp[t][k] === 1'b1);
        if (k < n && smp[(t + k * SW / n) % SW][k] !== smp[t][0]) bad++;
      end
      chk(32'(hi), (k < n) ? 32'(3 * PD) : 32'h0000_0000);
      chk(32'(bad), 32'h0000_0000);
      if (strapped && k >= n) chk_bit(oes[k], 1'b0);
    end
  endtask

  task automatic t_pwm();
    wr_reg(`REG_CTRL_OFS, 32'h0000_000B);
    wr_reg(`REG_DUTY_OFS, 32'h0000_0003);
    for (int n = 4; n > 1; n--) begin
      wr_reg(`REG_PHASE_OFS, 32'(n));
      cyc(110);
      t_phases(n, 1'b0);
    end
  endtask

  task automatic t_strap();
    for (int s = 1; s < 3; s++) begin
      do_reset(2'(s));
      wr_reg(`REG_CTRL_OFS, 32'h0000_000B);
      wr_reg(`REG_DUTY_OFS, 32'h0000_0003);
      wr_reg(`REG_PHASE_OFS, 32'h0000_0004);
      cyc(110);
      rd_reg(`REG_STATUS_OFS, d);
      chk({30'h0000_0000, d[10:9]}, 32'(s));
      t_phases(s + 1, 1'b1);
    end
  endtask

  // Block as slave follows the far master and its refresh pulse
  task automatic t_slave();
    int starts;
    do_reset(2'h0);
    @(posedge ref_clk_i);
    fdrv <= 1'b1;
    fcode <= 2'h2;
    wr_reg(`REG_CTRL_OFS, 32'h0000_000D);
    cyc(100);
    chk({30'h0000_0000, l_oe}, 32'h0000_0000);
    rd_reg(`REG_STATUS_OFS, d);
    chk({30'h0000_0000, d[7:6]}, 32'h0000_0002);
    chk({29'h0000_0000, d[2:0]}, 32'h0000_0003);
    @(posedge ref_clk_i);
    fcode <= 2'h1;
    cyc(40);
    rd_reg(`REG_STATUS_OFS, d);
    chk({29'h0000_0000, d[2:0]}, 32'h0000_0003);
    cyc(60);
    rd_reg(`REG_STATUS_OFS, d);
    chk({29'h0000_0000, d[2:0]}, 32'h0000_0002);
    @(posedge ref_clk_i);
    fcode <= 2'h3;
    cyc(30);
    starts = 0;
    @(posedge ref_clk_i);
    fboot <= 1'b1;
    @(posedge ref_clk_i);
    fboot <= 1'b0;
    for (int t = 0; t < 20; t++) begin
      #1 starts += (bstart === 1'b1);
      @(posedge ref_clk_i);
    end
    chk(32'(starts), 32'h0000_0001);
  endtask

  // Timeout guard, well beyond the roughly 1600 cycles of the run
  initial begin
    #200000;
    err_count++;
    finish_test();
  end

  // Main sequence
  initial begin
    do_reset(2'h0);
    t_regs();
    t_drv();
    t_master();
    t_boot();
    t_pwm();
    t_strap();
    t_slave();
    finish_test();
  end
endmodule
